// File: hw/ctac_pkg.sv
// ctac_pkg: shared constants and types for the camera trigger and acquisition controller
// assumes a 250 MHz system clock and a 32-bit classic wishbone register bus
package ctac_pkg;

	// clock and microsecond tick
	localparam int CLK_PERIOD_PS = 4000; // 250 MHz
	localparam int TICK_US = 1; // tick period in microseconds
	localparam int TICK_CYC = TICK_US * 1000000 / CLK_PERIOD_PS; // cycles per tick
	localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);

	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00; // trigger and exposure setup
	localparam logic [7:0] OFS_CMD = 8'h04; // write-only command pulses
	localparam logic [7:0] OFS_DELAY = 8'h08; // trig_postpone_us
	localparam logic [7:0] OFS_SPACE = 8'h0c; // burst_spacing_us
	localparam logic [7:0] OFS_EXPO = 8'h10; // timed exposure in us
	localparam logic [7:0] OFS_BURST = 8'h14; // burst_length
	localparam logic [7:0] OFS_STAT = 8'h18; // live status
	localparam logic [7:0] OFS_FRAMES = 8'h1c; // frames produced

	// command bit positions
	localparam int CMD_BEGIN = 0; // begin_capture_cmd
	localparam int CMD_END = 1; // end_capture_cmd
	localparam int CMD_HTRIG = 2; // host_trig_cmd

	// field widths
	localparam int US_W = 24; // microsecond fields
	localparam int BURST_W = 16; // burst_length
	localparam int CTRL_W = 7; // used control bits

	// reset values
	localparam logic [US_W-1:0] RST_DELAY = 24'h000000;
	localparam logic [US_W-1:0] RST_SPACE = 24'h0003e8;
	localparam logic [US_W-1:0] RST_EXPO = 24'h0003e8;
	localparam logic [BURST_W-1:0] RST_BURST = 16'h0001;

	// trigger type, trig_type_select
	typedef enum logic [1:0] {
		TYP_ACQ_START,
		TYP_ONE_FRAME, // one_frame_per_event
		TYP_COUNTED, // counted_burst_per_event
		TYP_LEVEL // level_gated_burst
	} ctac_type_e;

	// control register layout, bit 0 first from the bottom
	typedef struct packed {
		logic overlap; // sensor may integrate during readout
		logic width_exp; // integration_control_select: pulse_width_exposure
		logic origin_sw; // trig_origin_select: host command
		logic edge_fall; // trig_edge_select: falling edge
		ctac_type_e ttype; // trig_type_select
		logic gate; // trig_gate_enable
	} ctac_ctrl_s;

	localparam ctac_ctrl_s RST_CTRL = '0;

	// sensor control bundle
	typedef struct packed {
		logic integrate; // integration window, level
		logic readout_start; // one-cycle pulse at end of integration
	} ctac_sensor_s;

endpackage : ctac_pkg

// File: hw/ctac_top.sv
// ctac_top: acquisition and trigger controller, wishbone registers and frame sequencer
// assumes synchronous trigger line and sensor busy inputs on the single clock
//
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps

// Behaviour
// - ignore triggers until capture begun
// - stop finishes current frame, then halts
// - only continuous acquisition mode exists
// - gate enable decides triggered or free-run
// - acquisition-start type: one trigger, then continuous
// - frame-start type: one frame per trigger
// - counted burst: burst_length frames per trigger
// - level burst: frames while trigger active
// - trigger edge selectable rising or falling
// - trigger origin: hardware line or host
// - host trigger acts only with host origin
// - programmable microsecond delay before acting
// - burst spacing sets frame start interval in counted bursts only
// - slow sensor bursts at max rate
// - selected edge starts integration then readout
// - pulse width exposure starts on leading edge
// - pulse width exposure ends on trailing edge
// - overlap lets integration start during readout
// - auto exposure unavailable in trigger modes
// - counted burst from line or host event
// - timed exposure equals programmed microseconds
module ctac_top (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// trigger line and sensor
	input wire logic trig_line_i,
	input wire logic sensor_busy_i,
	output ctac_pkg::ctac_sensor_s sensor_o,
	// status levels
	output logic auto_exp_allow_o,
	output logic capture_active_o
);

	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT,
		ST_DELAY,
		ST_READY,
		ST_EXPOSE,
		ST_GAP
	} ctac_state_e;

	// registers
	ctac_pkg::ctac_ctrl_s ctrl_r; // control fields
	logic [ctac_pkg::US_W-1:0] delay_r; // trig_postpone_us
	logic [ctac_pkg::US_W-1:0] space_r; // burst_spacing_us
	logic [ctac_pkg::US_W-1:0] expo_r; // timed exposure
	logic [ctac_pkg::BURST_W-1:0] burst_r; // burst_length
	logic [31:0] frames_r; // frames produced
	logic [31:0] dat_r; // read data
	logic ack_r; // bus answer

	// sequencer state
	ctac_state_e st_r, st_nxt;
	logic [ctac_pkg::US_W-1:0] cnt_r; // delay or exposure count
	logic [ctac_pkg::US_W-1:0] cnt_val; // value loaded into cnt_r
	logic load_cnt;
	logic [ctac_pkg::US_W-1:0] spc_r; // frame start spacing count
	logic load_spc;
	logic [ctac_pkg::BURST_W-1:0] left_r, left_nxt; // frames left in burst
	logic started_r, started_nxt; // acquisition-start trigger seen
	logic stop_r, stop_nxt; // stop pending
	logic frame_end; // integration ends this cycle
	logic [7:0] div_r; // tick divider
	logic line_q_r; // previous trigger line
	ctac_pkg::ctac_sensor_s sensor_r;
	logic auto_r;

	// bus decode
	wire req = wb_cyc_i & wb_stb_i;
	wire wr_fire = req & wb_we_i & ack_r; // write lands at the acked edge
	wire hi_zero = (wb_adr_i[31:8] == 24'h000000);
	wire [7:0] ofs = wb_adr_i[7:0];
	wire sel_ctrl = hi_zero & (ofs == ctac_pkg::OFS_CTRL);
	wire sel_cmd = hi_zero & (ofs == ctac_pkg::OFS_CMD);
	wire sel_delay = hi_zero & (ofs == ctac_pkg::OFS_DELAY);
	wire sel_space = hi_zero & (ofs == ctac_pkg::OFS_SPACE);
	wire sel_expo = hi_zero & (ofs == ctac_pkg::OFS_EXPO);
	wire sel_burst = hi_zero & (ofs == ctac_pkg::OFS_BURST);
	wire sel_stat = hi_zero & (ofs == ctac_pkg::OFS_STAT);
	wire sel_frames = hi_zero & (ofs == ctac_pkg::OFS_FRAMES);

	// byte lane mask from sel
	logic [31:0] bmask;
	genvar gb;
	generate
		for (gb = 0; gb < 4; gb++)
		begin : g_lane
			assign bmask[gb*8 +: 8] = {8{wb_sel_i[gb]}};
		end
	endgenerate

	// merged write values, untouched lanes keep old contents
	wire [31:0] ctrl_old = {25'h0000000, ctrl_r};
	wire [31:0] ctrl_wv = (ctrl_old & ~bmask) | (wb_dat_i & bmask);
	wire [31:0] delay_wv = ({8'h00, delay_r} & ~bmask) | (wb_dat_i & bmask);
	wire [31:0] space_wv = ({8'h00, space_r} & ~bmask) | (wb_dat_i & bmask);
	wire [31:0] expo_wv = ({8'h00, expo_r} & ~bmask) | (wb_dat_i & bmask);
	wire [31:0] burst_wv = ({16'h0000, burst_r} & ~bmask) | (wb_dat_i & bmask);

	// command pulses, only lane 0 carries them
	wire cmd_ok = wr_fire & sel_cmd & wb_sel_i[0];
	wire begin_cmd = cmd_ok & wb_dat_i[ctac_pkg::CMD_BEGIN];
	wire end_cmd = cmd_ok & wb_dat_i[ctac_pkg::CMD_END];
	wire host_cmd = cmd_ok & wb_dat_i[ctac_pkg::CMD_HTRIG];

	// status word: busy, auto exposure allowed, stop pending, started, mode-is-continuous, state
	wire [2:0] st_code = st_r;
	wire [31:0] stat_w = {24'h000000, sensor_busy_i, auto_r, stop_r, started_r, 1'b1, st_code};

	// read mux, unmapped and command offsets read zero
	wire [31:0] rd_mux = sel_ctrl ? ctrl_old :
		sel_delay ? {8'h00, delay_r} :
		sel_space ? {8'h00, space_r} :
		sel_expo ? {8'h00, expo_r} :
		sel_burst ? {16'h0000, burst_r} :
		sel_stat ? stat_w :
		sel_frames ? frames_r : 32'h00000000;

	// microsecond tick from the system clock
	wire tick = (div_r == ctac_pkg::TICK_LAST);

	// trigger detection
	wire rise = trig_line_i & ~line_q_r;
	wire fall = ~trig_line_i & line_q_r;
	wire line_evt = ctrl_r.edge_fall ? fall : rise;
	wire host_evt = host_cmd & ctrl_r.origin_sw;
	wire trig_evt = ctrl_r.origin_sw ? host_evt : line_evt;
	// active level follows the edge choice; host source has no level
	wire lvl_active = ~ctrl_r.origin_sw & (ctrl_r.edge_fall ? ~trig_line_i : trig_line_i);
	wire is_level = (ctrl_r.ttype == ctac_pkg::TYP_LEVEL);
	wire trig_go = ctrl_r.gate & (is_level ? lvl_active : trig_evt);
	wire free_run = ~ctrl_r.gate;

	// exposure end: pulse width only for a line-driven one-frame trigger
	wire bulb = ctrl_r.width_exp & ~ctrl_r.origin_sw & (ctrl_r.ttype == ctac_pkg::TYP_ONE_FRAME);
	wire cnt_done = (cnt_r == '0);
	wire spc_done = (spc_r == '0);
	wire expose_end = bulb ? ~lvl_active : cnt_done;
	// without overlap the sensor must finish reading out first
	wire can_integ = ctrl_r.overlap | ~sensor_busy_i;
	wire last_burst = (left_r <= 16'h0001);

	// next-state logic of the frame sequencer
	always_comb
	begin
		st_nxt = st_r;
		load_cnt = 1'b0;
		cnt_val = cnt_r;
		load_spc = 1'b0;
		left_nxt = left_r;
		started_nxt = started_r;
		stop_nxt = stop_r | end_cmd;
		frame_end = 1'b0;
		unique case (st_r)
			// triggers do nothing until capture is begun
			ST_IDLE:
			begin
				if (begin_cmd)
				begin
					started_nxt = 1'b0;
					stop_nxt = 1'b0;
					st_nxt = free_run ? ST_READY : ST_WAIT;
				end
			end
			// armed; this is the only state that takes an event
			ST_WAIT:
			begin
				if (stop_nxt)
					st_nxt = ST_IDLE;
				// a trigger that finds the sensor still reading out is dropped, not queued
				else if (trig_go & can_integ)
				begin
					st_nxt = ST_DELAY;
					load_cnt = 1'b1;
					cnt_val = delay_r;
					left_nxt = burst_r;
					if (ctrl_r.ttype == ctac_pkg::TYP_ACQ_START)
						started_nxt = 1'b1;
				end
			end
			// trigger postponement, no frame in flight yet
			ST_DELAY:
			begin
				if (stop_nxt)
					st_nxt = ST_IDLE;
				else if (cnt_done)
					st_nxt = ST_READY;
			end
			// waiting on the sensor before integration
			ST_READY:
			begin
				if (stop_nxt)
					st_nxt = ST_IDLE;
				else if (can_integ)
				begin
					st_nxt = ST_EXPOSE;
					load_cnt = 1'b1;
					cnt_val = expo_r;
					load_spc = 1'b1;
				end
			end
			// integration; a stop here waits for the frame to close
			ST_EXPOSE:
			begin
				if (expose_end)
				begin
					frame_end = 1'b1;
					if (stop_nxt)
						st_nxt = ST_IDLE;
					else if (free_run | (ctrl_r.ttype == ctac_pkg::TYP_ACQ_START))
						st_nxt = ST_READY;
					else if (ctrl_r.ttype == ctac_pkg::TYP_ONE_FRAME)
						st_nxt = ST_WAIT;
					else if (ctrl_r.ttype == ctac_pkg::TYP_COUNTED)
					begin
						left_nxt = left_r - 16'h0001;
						st_nxt = last_burst ? ST_WAIT : ST_GAP;
					end
					else
						st_nxt = lvl_active ? ST_READY : ST_WAIT;
				end
			end
			// spacing from one burst frame start to the next
			ST_GAP:
			begin
				if (stop_nxt)
					st_nxt = ST_IDLE;
				else if (spc_done)
					st_nxt = ST_READY;
			end
			default:
				st_nxt = ST_IDLE;
		endcase
	end

	// bus answer: one wait state, ack drops the cycle after it rose
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_r <= 1'b0;
		else
			ack_r <= req & ~ack_r;
	end

	// read data captured in the request cycle, stable while ack is high
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_r <= 32'h00000000;
		else if (req & ~ack_r)
			dat_r <= rd_mux;
	end

	// control register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ctrl_r <= ctac_pkg::RST_CTRL;
		else if (wr_fire & sel_ctrl)
			ctrl_r <= ctrl_wv[ctac_pkg::CTRL_W-1:0];
	end

	// timing registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			delay_r <= ctac_pkg::RST_DELAY;
			space_r <= ctac_pkg::RST_SPACE;
			expo_r <= ctac_pkg::RST_EXPO;
			burst_r <= ctac_pkg::RST_BURST;
		end
		else
		begin
			if (wr_fire & sel_delay)
				delay_r <= delay_wv[ctac_pkg::US_W-1:0];
			if (wr_fire & sel_space)
				space_r <= space_wv[ctac_pkg::US_W-1:0];
			if (wr_fire & sel_expo)
				expo_r <= expo_wv[ctac_pkg::US_W-1:0];
			if (wr_fire & sel_burst)
				burst_r <= burst_wv[ctac_pkg::BURST_W-1:0];
		end
	end

	// microsecond divider
	always_ff @(posedge clk_i)
	begin
		if (rst_i | tick)
			div_r <= 8'h00;
		else
			div_r <= div_r + 8'h01;
	end

	// sequencer state and flags
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_r <= ST_IDLE;
			left_r <= '0;
			started_r <= 1'b0;
			stop_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			left_r <= left_nxt;
			started_r <= started_nxt;
			stop_r <= (st_nxt == ST_IDLE) ? 1'b0 : stop_nxt;
		end
	end

	// delay or exposure counter, steps on the tick
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cnt_r <= '0;
		else if (load_cnt)
			cnt_r <= cnt_val;
		else if (tick & ~cnt_done)
			cnt_r <= cnt_r - 24'h000001;
	end

	// spacing counter runs from each integration start
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			spc_r <= '0;
		else if (load_spc)
			spc_r <= space_r;
		else if (tick & ~spc_done)
			spc_r <= spc_r - 24'h000001;
	end

	// edge history of the trigger line
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			line_q_r <= 1'b0;
		else
			line_q_r <= trig_line_i;
	end

	// sensor controls registered so they glitch-free leave the block
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			sensor_r <= '0;
		else
		begin
			sensor_r.integrate <= (st_nxt == ST_EXPOSE);
			sensor_r.readout_start <= frame_end;
		end
	end

	// auto exposure only while triggering is off
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			auto_r <= 1'b1;
		else
			auto_r <= ~ctrl_r.gate;
	end

	// frame counter, wraps
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			frames_r <= 32'h00000000;
		else if (frame_end)
			frames_r <= frames_r + 32'h00000001;
	end

	// outputs
	assign wb_dat_o = dat_r;
	assign wb_ack_o = ack_r;
	assign sensor_o = sensor_r;
	assign auto_exp_allow_o = auto_r;
	assign capture_active_o = (st_r != ST_IDLE);

endmodule : ctac_top

// File: verif/ctac_sensor_model.sv
// ctac_sensor_model: image sensor stand-in, busy for a fixed readout span
// assumes readout_start is a one-cycle pulse on the shared clock
`timescale 1ns/1ps
module ctac_sensor_model #(
	parameter int READ_CYC = 100 // readout length in clocks
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// controller side
	input wire ctac_pkg::ctac_sensor_s sensor_i,
	output logic busy_o
);
	int cnt_r; // readout cycles left

	// readout starts on the pulse and holds busy, so overlap off must wait
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cnt_r <= 0;
		else if (sensor_i.readout_start)
			cnt_r <= READ_CYC;
		else if (cnt_r != 0)
			cnt_r <= cnt_r - 1;
	end

	assign busy_o = (cnt_r != 0); // level while reading out
endmodule : ctac_sensor_model

// File: verif/ctac_checker.sv
// ctac_checker: port assertions on the trigger controller
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
module ctac_checker (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// sensor and status
	input wire logic trig_line_i,
	input wire logic sensor_busy_i,
	input wire ctac_pkg::ctac_sensor_s sensor_o,
	input wire logic auto_exp_allow_o,
	input wire logic capture_active_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o; // new request
	wire gate_wr = req & wb_we_i & (wb_adr_i == 32'h0) & wb_sel_i[0] & wb_dat_i[0]; // gate on
	// begin command landing at its acked edge
	wire begin_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & (wb_adr_i == 32'h00000004) & wb_sel_i[0] & wb_dat_i[0];

	a_ack_latency: assert property (req |=> wb_ack_o) else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_unmapped_zero: assert property (req & ~wb_we_i & (wb_adr_i == 32'h20) |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_ro_pulse: assert property (sensor_o.readout_start |=> !sensor_o.readout_start)
		else $error("readout pulse too long");
	a_ro_at_fall: assert property (sensor_o.readout_start |-> $fell(sensor_o.integrate))
		else $error("readout not at end of integration");
	a_int_started: assert property ($rose(sensor_o.integrate) |-> capture_active_o)
		else $error("integration while idle");
	a_int_whole: assert property (sensor_o.integrate |-> capture_active_o)
		else $error("frame cut short");
	a_auto_gate: assert property (gate_wr |-> ##[1:3] !auto_exp_allow_o)
		else $error("auto exposure left on");
	a_begin_only: assert property ($rose(capture_active_o) |-> $past(begin_wr))
		else $error("capture began without begin command");
	a_stop_whole: assert property ($fell(capture_active_o) && $past(sensor_o.integrate) |-> sensor_o.readout_start)
		else $error("capture ended inside a frame");
endmodule : ctac_checker

bind ctac_top ctac_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .trig_line_i(trig_line_i), .sensor_busy_i(sensor_busy_i), .sensor_o(sensor_o),
	.auto_exp_allow_o(auto_exp_allow_o), .capture_active_o(capture_active_o));

// File: verif/tb.sv
// tb: self-checking bench for the trigger controller
// assumes the sensor model on the far side and a 250 MHz clock
`timescale 1ns/1ps
module tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, trig_line_i = 1'b0; // bus and line drives
	logic [31:0] adr = 32'h0, dat = 32'h0, q, f0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, sensor_busy_i, auto_exp_allow_o, capture_active_o;
	ctac_pkg::ctac_sensor_s sensor_o;
	int bad_count = 0, samples_checked = 0, run_len = 0, last_len = 0;

	always #2 clk_i = ~clk_i;

	ctac_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trig_line_i(trig_line_i),
		.sensor_busy_i(sensor_busy_i), .sensor_o(sensor_o), .auto_exp_allow_o(auto_exp_allow_o),
		.capture_active_o(capture_active_o));
	ctac_sensor_model model (.clk_i(clk_i), .rst_i(rst_i), .sensor_i(sensor_o), .busy_o(sensor_busy_i));

	// integration length probe, kept when integrate drops
	always @(posedge clk_i)
	begin
		if (sensor_o.integrate === 1'b1)
			run_len <= run_len + 1;
		else
		begin
			if (run_len != 0)
				last_len <= run_len;
			run_len <= 0;
		end
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// one classic cycle, held until ack, read data into q
	// waits as long as ack takes; only the watchdog ends a hang
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {24'h0, a};
		dat <= d;
		do
			@(posedge clk_i);
		while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus

	task idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask : idle

	task end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test

	// reset values and an unmapped place
	task t_regs;
		logic [7:0] a[6] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
		logic [31:0] e[6] = '{32'h0, 32'h0, 32'h3e8, 32'h3e8, 32'h1, 32'h0};
		for (int i = 0; i < 6; i++)
		begin
			bus(1'b0, a[i], 32'h0);
			chk(q, e[i]);
		end
		chk(32'(auto_exp_allow_o), 32'h1);
		$display("regs done");
	endtask : t_regs

	// one frame per line edge, nothing before begin
	task t_one;
		bus(1'b1, 8'h00, 32'h3);
		bus(1'b1, 8'h10, 32'h2);
		bus(1'b0, 8'h1c, 32'h0);
		f0 = q;
		idle(1);
		trig_line_i <= 1'b1;
		idle(5);
		trig_line_i <= 1'b0;
		idle(1000);
		bus(1'b0, 8'h1c, 32'h0);
		chk(q, f0);
		chk(32'(auto_exp_allow_o), 32'h0);
		bus(1'b1, 8'h04, 32'h1);
		trig_line_i <= 1'b1;
		idle(5);
		trig_line_i <= 1'b0;
		idle(1500);
		bus(1'b0, 8'h1c, 32'h0);
		chk(q, f0 + 1);
		chk(32'(last_len > 250 && last_len <= 500), 32'h1);
		$display("one frame done");
	endtask : t_one

	// falling edge selected: the rise alone starts nothing
	task t_fall;
		bus(1'b1, 8'h00, 32'hb);
		bus(1'b0, 8'h1c, 32'h0);
		f0 = q;
		trig_line_i <= 1'b1;
		idle(1200);
		bus(1'b0, 8'h1c, 32'h0);
		chk(q, f0);
		trig_line_i <= 1'b0;
		idle(1200);
		bus(1'b0, 8'h1c, 32'h0);
		chk(q, f0 + 1);
		bus(1'b1, 8'h04, 32'h2);
		idle(5);
		chk(32'(capture_active_o), 32'h0);
		$display("falling edge done");
	endtask : t_fall

	// counted burst from host command, ignored under line origin
	task t_host;
		bus(1'b1, 8'h00, 32'h5);
		bus(1'b1, 8'h14, 32'h3);
		bus(1'b1, 8'h0c, 32'ha);
		bus(1'b1, 8'h10, 32'h1);
		bus(1'b0, 8'h1c, 32'h0);
		f0 = q;
		bus(1'b1, 8'h04, 32'h1);
		bus(1'b1, 8'h04, 32'h4);
		idle(2000);
		bus(1'b0, 8'h1c, 32'h0);
		chk(q, f0);
		bus(1'b1, 8'h00, 32'h15);
		bus(1'b1, 8'h04, 32'h4);
		idle(9000);
		bus(1'b0, 8'h1c, 32'h0);
		chk(q, f0 + 3);
		bus(1'b1, 8'h04, 32'h2);
		$display("burst done");
	endtask : t_host

	// free run with gate off, stop lets the frame finish
	task t_free;
		bus(1'b1, 8'h00, 32'h0);
		bus(1'b0, 8'h1c, 32'h0);
		f0 = q;
		bus(1'b1, 8'h04, 32'h1);
		idle(3000);
		bus(1'b1, 8'h04, 32'h2);
		idle(1000);
		chk(32'(capture_active_o), 32'h0);
		bus(1'b0, 8'h1c, 32'h0);
		chk(32'(q - f0 >= 2), 32'h1);
		f0 = q;
		idle(1000);
		bus(1'b0, 8'h1c, 32'h0);
		chk(q, f0);
		$display("free run done");
	endtask : t_free

	// acquisition-start trigger after a delay, then back-to-back frames under overlap
	task t_acq;
		bus(1'b1, 8'h00, 32'h41);
		bus(1'b1, 8'h08, 32'h4);
		bus(1'b1, 8'h10, 32'h0);
		bus(1'b0, 8'h1c, 32'h0);
		f0 = q;
		bus(1'b1, 8'h04, 32'h1);
		idle(1500);
		bus(1'b0, 8'h1c, 32'h0);
		chk(q, f0);
		trig_line_i <= 1'b1;
		idle(3);
		trig_line_i <= 1'b0;
		idle(700);
		chk(32'(sensor_o.integrate), 32'h0);
		idle(1500);
		bus(1'b0, 8'h1c, 32'h0);
		chk(32'(q - f0 >= 100), 32'h1);
		bus(1'b1, 8'h04, 32'h2);
		idle(20);
		chk(32'(capture_active_o), 32'h0);
		$display("acquisition start done");
	endtask : t_acq

	// level-gated burst: frames only while the line stays high
	task t_level;
		bus(1'b1, 8'h00, 32'h7);
		bus(1'b1, 8'h08, 32'h0);
		bus(1'b1, 8'h10, 32'h1);
		bus(1'b0, 8'h1c, 32'h0);
		f0 = q;
		bus(1'b1, 8'h04, 32'h1);
		trig_line_i <= 1'b1;
		idle(2000);
		trig_line_i <= 1'b0;
		idle(800);
		bus(1'b0, 8'h1c, 32'h0);
		chk(32'(q - f0 >= 3), 32'h1);
		f0 = q;
		idle(1000);
		bus(1'b0, 8'h1c, 32'h0);
		chk(q, f0);
		bus(1'b1, 8'h04, 32'h2);
		$display("level burst done");
	endtask : t_level

	// pulse-width exposure: integration follows the line pulse, not the timed value
	task t_bulb;
		bus(1'b1, 8'h00, 32'h23);
		bus(1'b1, 8'h04, 32'h1);
		trig_line_i <= 1'b1;
		idle(1200);
		trig_line_i <= 1'b0;
		idle(20);
		chk(32'(last_len > 1190 && last_len <= 1200), 32'h1);
		bus(1'b1, 8'h04, 32'h2);
		$display("pulse width done");
	endtask : t_bulb

	// watchdog, run needs about 30000 cycles
	initial
	begin
		#(4 * 60000);
		bad_count++;
		end_of_test;
	end

	initial
	begin
		idle(8);
		rst_i <= 1'b0;
		t_regs;
		t_one;
		t_fall;
		t_host;
		t_free;
		t_acq;
		t_level;
		t_bulb;
		end_of_test;
	end
endmodule : tb
